// >>> port_mode_pkg.sv
/*
 * constants, encodings and reset values shared by the receive port
 * pin-select block and its sub-modules.
 * assumes every file that uses it imports it whole.
 */
package port_mode_pkg;

	// --------------------------------------------------------------
	// framing mode field codes
	// --------------------------------------------------------------
	localparam logic [2:0] FM_DS3_CBIT   = 3'h0;
	localparam logic [2:0] FM_DS3_M13    = 3'h1;
	localparam logic [2:0] FM_E3_G751    = 3'h2;
	localparam logic [2:0] FM_E3_G832    = 3'h3;
	localparam logic [2:0] FM_DS3_CLEAR  = 3'h4;
	localparam logic [1:0] FM_E3_CLEAR_HI = 2'h3;
	localparam int         FM_CLEAR_BIT  = 2;

	// --------------------------------------------------------------
	// line mode field codes
	// --------------------------------------------------------------
	localparam logic [2:0] LM_ALL_OFF    = 3'h0;
	localparam logic [2:0] LM_LIU_ON     = 3'h1;
	localparam logic [2:0] LM_JA_TX      = 3'h2;
	localparam logic [2:0] LM_JA_RX      = 3'h3;
	localparam int         LM_UNI_BIT    = 2;

	// --------------------------------------------------------------
	// reset values and counts
	// --------------------------------------------------------------
	localparam logic [2:0] FM_RESET      = 3'h0;
	localparam logic [2:0] LM_RESET      = 3'h0;
	localparam int         INTEG_COUNT   = 5;
	localparam int         UNSTABLE_COUNT = 8;
	localparam int         OVH_WIDTH     = 8;
	localparam int         BYTE_BITS     = 8;
	localparam int         BPV_WIDTH     = 16;
	localparam int         BIT_DIV       = 4;
	localparam logic [7:0] BYTE_RESET    = 8'h00;

	typedef enum logic [1:0] {
		LC_B3ZS,
		LC_HDB3,
		LC_AMI,
		LC_NONE
	} line_code_t;

endpackage

// >>> ovh_field_if.sv
/*
 * carries one integrated overhead field between the port block and
 * its integrator.
 * assumes both ends run on the same receive clock.
 */
`timescale 1ns/10ps
interface ovh_field_if #(
	parameter int W = 8
);
	logic         occur;
	logic [W-1:0] value;
	logic [W-1:0] stored;
	logic         unstable;

	modport src (
		output occur,
		output value,
		input  stored,
		input  unstable
	);
	modport integ (
		input  occur,
		input  value,
		output stored,
		output unstable
	);
endinterface

// >>> ovh_integrator.sv
/*
 * integration of a received overhead field with an unstable flag.
 * assumes one occur pulse per received field occurrence.
 */
`timescale 1ns/10ps
module ovh_integrator #(
	parameter int W = 8
) (
	input  wire logic  i_ref_clk,
	input  wire logic  i_rst,
	ovh_field_if.integ f
);
	import port_mode_pkg::*;

	logic [W-1:0] prev_reg;
	logic [W-1:0] stored_reg;
	logic [3:0]   same_reg;
	logic [3:0]   bad_reg;
	logic         unstable_reg;
	wire  logic   same_val = (f.value == prev_reg);
	wire  logic   mismatch = (f.value != stored_reg) && !same_val;
	wire  logic [3:0] same_next = same_val ?
		((same_reg == 4'(INTEG_COUNT)) ? same_reg : same_reg + 4'h1) : 4'h1;
	wire  logic [3:0] bad_next = mismatch ?
		((bad_reg == 4'(UNSTABLE_COUNT)) ? bad_reg : bad_reg + 4'h1) : 4'h0;
	wire  logic   settled  = (same_next == 4'(INTEG_COUNT));

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			prev_reg     <= '0;
			stored_reg   <= '0;
			same_reg     <= 4'h0;
			bad_reg      <= 4'h0;
			unstable_reg <= 1'b0;
		end else if (f.occur) begin
			prev_reg <= f.value;
			same_reg <= same_next;
			bad_reg  <= bad_next;
			if (settled)
				stored_reg <= f.value;
			if (bad_next == 4'(UNSTABLE_COUNT))
				unstable_reg <= 1'b1;
			else if (settled)
				unstable_reg <= 1'b0;
		end
	end

	assign f.stored   = stored_reg;
	assign f.unstable = unstable_reg;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	store_after_five_a: assert property (
		f.occur && stored_reg != f.value && same_reg < 4'(INTEG_COUNT - 1)
		|=> stored_reg == $past(stored_reg))
		else $error("stored value changed before five alike");
	unstable_rise_a: assert property (
		f.occur && bad_reg == 4'(UNSTABLE_COUNT - 1) && mismatch
		|=> unstable_reg)
		else $error("unstable not raised after eight mismatches");
	unstable_clear_a: assert property (
		f.occur && same_val && same_reg == 4'(INTEG_COUNT - 1)
		|=> !unstable_reg && stored_reg == $past(f.value))
		else $error("five alike did not clear and store");
endmodule

// >>> msb_serdes.sv
/*
 * byte serialiser and deserialiser, most significant bit first.
 * assumes i_bit_en is a one-cycle pulse at the serial bit rate.
 */
`timescale 1ns/10ps
module msb_serdes (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_bit_en,
	input  wire logic       i_load,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_rx_bit,
	input  wire logic       i_rx_bit_valid,
	output logic            o_tx_bit,
	output logic            o_tx_busy,
	output logic [7:0]      o_rx_byte,
	output logic            o_rx_byte_valid
);
	import port_mode_pkg::*;

	logic [7:0] tx_sh_reg;
	logic [3:0] tx_cnt_reg;
	logic [7:0] rx_sh_reg;
	logic [2:0] rx_cnt_reg;
	wire  logic [7:0] rx_next = {rx_sh_reg[6:0], i_rx_bit};
	wire  logic rx_take = i_bit_en && i_rx_bit_valid;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tx_sh_reg  <= BYTE_RESET;
			tx_cnt_reg <= 4'h0;
			o_tx_bit   <= 1'b0;
			o_tx_busy  <= 1'b0;
		end else if (i_load && tx_cnt_reg == 4'h0) begin
			tx_sh_reg  <= i_tx_byte;
			tx_cnt_reg <= 4'(BYTE_BITS);
			o_tx_busy  <= 1'b1;
		end else if (i_bit_en && tx_cnt_reg != 4'h0) begin
			o_tx_bit   <= tx_sh_reg[7];
			tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
			tx_cnt_reg <= tx_cnt_reg - 4'h1;
			o_tx_busy  <= (tx_cnt_reg != 4'h1);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_sh_reg       <= BYTE_RESET;
			rx_cnt_reg      <= 3'h0;
			o_rx_byte       <= BYTE_RESET;
			o_rx_byte_valid <= 1'b0;
		end else begin
			o_rx_byte_valid <= 1'b0;
			if (rx_take) begin
				// first bit lands in bit 7
				rx_sh_reg  <= rx_next;
				rx_cnt_reg <= rx_cnt_reg + 3'h1;
				if (rx_cnt_reg == 3'(BYTE_BITS - 1)) begin
					o_rx_byte       <= rx_next;
					o_rx_byte_valid <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	tx_msb_first_a: assert property (
		i_bit_en && tx_cnt_reg == 4'(BYTE_BITS)
		|=> o_tx_bit == $past(tx_sh_reg[7]) && o_tx_busy)
		else $error("serial byte did not start with bit 7");
	rx_msb_first_a: assert property (
		rx_take && rx_cnt_reg == 3'(BYTE_BITS - 1)
		|=> o_rx_byte_valid && o_rx_byte[0] == $past(i_rx_bit))
		else $error("last received bit not in bit 0");
endmodule

// >>> port_mode_rx_pin_select.sv
/*
 * per-port mode decode and receive serial-port pin select: framing
 * and line mode decode, line code choice, loopback rails, unipolar
 * violation counting, overhead integration and byte ordering.
 * assumes framer signals share i_ref_clk; line pins are asynchronous.
 */
// Summary of operation
// - enable/frame pin: data enable, frame start, constant
// - clock pin gapped by data enable unless ungapped
// - unselected pin functions feed constant zero inside
// - decode framing mode field into six modes
// - test pattern engine enabled in every mode
// - decode line mode field: interface, attenuator, unipolar
// - B3ZS or HDB3, AMI when both suppressions disabled
// - unipolar: no coding, count external violation pulses
// - loopback without line interface loops rails digitally
// - transmit bytes leave most significant bit first
// - receive bit one stored in bit seven
// - integrated field stored after five alike
// - eight mismatches raise unstable indication
// - five alike clear unstable indication
`timescale 1ns/10ps
module port_mode_rx_pin_select #(
	parameter int BIT_DIVIDE = port_mode_pkg::BIT_DIV,
	parameter int BPV_W      = port_mode_pkg::BPV_WIDTH
) (
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	input  wire logic [2:0]               i_framing_mode_field,
	input  wire logic [2:0]               i_line_mode_field,
	input  wire logic                     i_rx_frame_start_select,
	input  wire logic                     i_rx_clock_select,
	input  wire logic                     i_tx_zero_suppress_disable,
	input  wire logic                     i_rx_zero_suppress_disable,
	input  wire logic                     i_analog_loopback,
	input  wire logic                     i_bert_enable,
	input  wire logic                     i_rx_data_enable,
	input  wire logic                     i_rx_frame_start,
	input  wire logic                     i_rx_serial_data,
	input  wire logic                     i_frame_start_pin,
	input  wire logic                     i_code_violation,
	input  wire logic                     i_tx_line_clock,
	input  wire logic                     i_tx_positive_rail,
	input  wire logic                     i_tx_negative_rail,
	input  wire logic                     i_rx_line_clock,
	input  wire logic                     i_rx_positive_rail,
	input  wire logic                     i_rx_neg_or_violation_in,
	input  wire logic                     i_ovh_occur,
	input  wire logic [7:0]               i_ovh_value,
	input  wire logic                     i_tx_load,
	input  wire logic [7:0]               i_tx_byte,
	output logic                          o_rx_serial_data_out,
	output logic                          o_rx_enable_frame_out,
	output logic                          o_rx_clock_out,
	output logic                          o_frame_start_int,
	output port_mode_pkg::line_code_t     o_line_code,
	output logic                          o_line_interface_unit,
	output logic                          o_jitter_attenuator_tx,
	output logic                          o_jitter_attenuator_rx,
	output logic                          o_unipolar_line_mode,
	output logic                          o_clear_channel_mode,
	output logic                          o_ds3_rate,
	output logic                          o_bert_active,
	output logic                          o_rx_line_clock_int,
	output logic                          o_rx_positive_int,
	output logic                          o_rx_negative_int,
	output logic [BPV_W-1:0]              o_bipolar_violation_counter,
	output logic                          o_tx_serial_bit,
	output logic                          o_tx_busy,
	output logic [7:0]                    o_rx_byte,
	output logic                          o_rx_byte_valid,
	output logic [7:0]                    o_ovh_stored,
	output logic                          o_ovh_unstable
);
	import port_mode_pkg::*;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic fm_is_ds3(input logic [2:0] fm);
		fm_is_ds3 = (fm == FM_DS3_CBIT) || (fm == FM_DS3_M13) ||
			(fm == FM_DS3_CLEAR);
	endfunction

	function automatic logic lm_liu_on(input logic [2:0] lm);
		lm_liu_on = (lm == LM_LIU_ON) || (lm == LM_JA_TX) ||
			(lm == LM_JA_RX);
	endfunction

	// ------------------------------------------------------------------
	// held mode bits
	// ------------------------------------------------------------------
	logic [2:0] fm_reg;
	logic [2:0] lm_reg;
	logic       fs_sel_reg;
	logic       clk_sel_reg;
	logic       tx_zero_suppress_disable_reg;
	logic       rx_zero_suppress_disable_reg;
	logic       alb_reg;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			fm_reg      <= FM_RESET;
			lm_reg      <= LM_RESET;
			fs_sel_reg  <= 1'b0;
			clk_sel_reg <= 1'b0;
			tx_zero_suppress_disable_reg    <= 1'b0;
			rx_zero_suppress_disable_reg    <= 1'b0;
			alb_reg     <= 1'b0;
		end else begin
			fm_reg      <= i_framing_mode_field;
			lm_reg      <= i_line_mode_field;
			fs_sel_reg  <= i_rx_frame_start_select;
			clk_sel_reg <= i_rx_clock_select;
			tx_zero_suppress_disable_reg    <= i_tx_zero_suppress_disable;
			rx_zero_suppress_disable_reg    <= i_rx_zero_suppress_disable;
			alb_reg     <= i_analog_loopback;
		end
	end

	// ------------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------------
	// framing and line mode decode
	wire logic channelized_framing = ~fm_reg[FM_CLEAR_BIT];
	wire logic clear_channel_high  = (fm_reg[2:1] == FM_E3_CLEAR_HI);
	wire logic ds3_rate            = fm_is_ds3(fm_reg);
	wire logic unipolar            = lm_reg[LM_UNI_BIT];
	wire logic liu_on              = lm_liu_on(lm_reg);
	wire logic ja_tx               = (lm_reg == LM_JA_TX);
	wire logic ja_rx               = (lm_reg == LM_JA_RX);
	// ds3 rates b3zs, e3 rates hdb3; both disable bits force ami
	wire logic ami_sel             = tx_zero_suppress_disable_reg & rx_zero_suppress_disable_reg;
	line_code_t code_next;
	assign code_next = unipolar ? LC_NONE :
		ami_sel ? LC_AMI : ds3_rate ? LC_B3ZS : LC_HDB3;
	wire logic ungapped            = ~channelized_framing | clk_sel_reg;

	// ------------------------------------------------------------------
	// bit-rate enable
	// ------------------------------------------------------------------
	logic [7:0] div_reg;
	wire  logic bit_en = (div_reg == 8'(BIT_DIVIDE - 1));

	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			div_reg <= 8'h00;
		else
			div_reg <= bit_en ? 8'h00 : div_reg + 8'h01;
	end

	// ------------------------------------------------------------------
	// line pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] lclk_sync_reg;
	logic [1:0] pos_sync_reg;
	logic [1:0] neg_sync_reg;
	logic [1:0] fsp_sync_reg;
	logic       neg_prev_reg;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			lclk_sync_reg <= 2'h0;
			pos_sync_reg  <= 2'h0;
			neg_sync_reg  <= 2'h0;
			fsp_sync_reg  <= 2'h0;
			neg_prev_reg  <= 1'b0;
		end else begin
			lclk_sync_reg <= {lclk_sync_reg[0], i_rx_line_clock};
			pos_sync_reg  <= {pos_sync_reg[0], i_rx_positive_rail};
			neg_sync_reg  <= {neg_sync_reg[0], i_rx_neg_or_violation_in};
			fsp_sync_reg  <= {fsp_sync_reg[0], i_frame_start_pin};
			neg_prev_reg  <= neg_sync_reg[1];
		end
	end

	// digital loop when line interface is off
	wire logic dig_loop  = alb_reg & ~liu_on;
	wire logic lclk_sel  = dig_loop ? i_tx_line_clock : lclk_sync_reg[1];
	wire logic pos_sel   = dig_loop ? i_tx_positive_rail : pos_sync_reg[1];
	// outside the digital loop, neg rail reads zero when the pin is a violation input
	wire logic neg_sel   = dig_loop ? i_tx_negative_rail :
		(unipolar ? 1'b0 : neg_sync_reg[1]);
	wire logic ext_pulse = neg_sync_reg[1] & ~neg_prev_reg;
	// unipolar counts pin pulses, coded modes count decoder hits
	wire logic bpv_hit   = unipolar ? ext_pulse : i_code_violation;

	// ------------------------------------------------------------------
	// receive serial port pins
	// ------------------------------------------------------------------
	// pin function select
	wire logic enfr_next = channelized_framing ?
		(fs_sel_reg ? i_rx_frame_start : i_rx_data_enable) :
		clear_channel_high;
	// gap only in channelized modes with clock select low
	wire logic clk_step  = bit_en & (ungapped | i_rx_data_enable);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rx_serial_data_out  <= 1'b0;
			o_rx_enable_frame_out <= 1'b0;
			o_rx_clock_out        <= 1'b0;
			o_frame_start_int     <= 1'b0;
		end else begin
			o_rx_serial_data_out  <= i_rx_serial_data;
			o_rx_enable_frame_out <= enfr_next;
			if (clk_step)
				o_rx_clock_out <= ~o_rx_clock_out;
			// frame-start pin unused in clear channel
			o_frame_start_int <= channelized_framing & fsp_sync_reg[1];
		end
	end

	// ------------------------------------------------------------------
	// mode outputs, rails and violation count
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_line_code                 <= LC_B3ZS;
			o_line_interface_unit       <= 1'b0;
			o_jitter_attenuator_tx      <= 1'b0;
			o_jitter_attenuator_rx      <= 1'b0;
			o_unipolar_line_mode        <= 1'b0;
			o_clear_channel_mode        <= 1'b0;
			o_ds3_rate                  <= 1'b1;
			o_bert_active               <= 1'b0;
			o_rx_line_clock_int         <= 1'b0;
			o_rx_positive_int           <= 1'b0;
			o_rx_negative_int           <= 1'b0;
			o_bipolar_violation_counter <= '0;
		end else begin
			o_line_code            <= code_next;
			o_line_interface_unit  <= liu_on;
			o_jitter_attenuator_tx <= ja_tx;
			o_jitter_attenuator_rx <= ja_rx;
			o_unipolar_line_mode   <= unipolar;
			o_clear_channel_mode   <= ~channelized_framing;
			o_ds3_rate             <= ds3_rate;
			// no mode gating of the pattern engine
			o_bert_active          <= i_bert_enable;
			o_rx_line_clock_int    <= lclk_sel;
			o_rx_positive_int      <= pos_sel;
			o_rx_negative_int      <= neg_sel;
			// counter wraps; software reads it as a running total
			if (bpv_hit)
				o_bipolar_violation_counter <=
					o_bipolar_violation_counter + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// overhead integration and byte ordering
	// ------------------------------------------------------------------
	ovh_field_if #(.W(OVH_WIDTH)) ovh_f ();

	assign ovh_f.occur = i_ovh_occur;
	assign ovh_f.value = i_ovh_value;
	assign o_ovh_stored   = ovh_f.stored;
	assign o_ovh_unstable = ovh_f.unstable;

	ovh_integrator #(.W(OVH_WIDTH)) u_integ (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.f         (ovh_f.integ)
	);

	msb_serdes u_serdes (
		.i_ref_clk       (i_ref_clk),
		.i_rst           (i_rst),
		.i_bit_en        (bit_en),
		.i_load          (i_tx_load),
		.i_tx_byte       (i_tx_byte),
		.i_rx_bit        (i_rx_serial_data),
		.i_rx_bit_valid  (i_rx_data_enable),
		.o_tx_bit        (o_tx_serial_bit),
		.o_tx_busy       (o_tx_busy),
		.o_rx_byte       (o_rx_byte),
		.o_rx_byte_valid (o_rx_byte_valid)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_mode_held;
		$stable(i_framing_mode_field) [*2];
	endsequence

	enfr_select_a: assert property (
		!i_rst && channelized_framing && !fs_sel_reg
		|=> o_rx_enable_frame_out == $past(i_rx_data_enable))
		else $error("enable pin not showing data enable");
	enfr_clear_a: assert property (
		!channelized_framing |=> o_rx_enable_frame_out == $past(fm_reg[1]))
		else $error("clear channel level wrong");
	clock_gap_a: assert property (
		bit_en && channelized_framing && !clk_sel_reg && !i_rx_data_enable
		|=> $stable(o_rx_clock_out))
		else $error("gapped clock moved without data enable");
	clock_free_a: assert property (
		bit_en && ungapped |=> o_rx_clock_out != $past(o_rx_clock_out))
		else $error("ungapped clock stalled");
	unused_zero_a: assert property (
		s_mode_held ##0 i_framing_mode_field[2] ##1 1'b1
		|=> !o_frame_start_int)
		else $error("unused frame-start function not zero");
	bert_any_mode_a: assert property (
		!i_rst && i_bert_enable |=> o_bert_active)
		else $error("pattern engine gated by mode");
	line_mode_a: assert property (
		lm_reg[2] |=> !o_line_interface_unit && o_unipolar_line_mode &&
			!o_jitter_attenuator_tx && !o_jitter_attenuator_rx)
		else $error("unipolar line mode decode wrong");
	line_code_a: assert property (
		!unipolar && !ami_sel && fm_reg == FM_E3_G751
		|=> o_line_code == LC_HDB3)
		else $error("e3 mode did not select hdb3");
	uni_count_a: assert property (
		unipolar && ext_pulse && !i_code_violation
		|=> o_bipolar_violation_counter ==
			$past(o_bipolar_violation_counter) + 1'b1)
		else $error("external pulse not counted");
	dig_loop_a: assert property (
		alb_reg && lm_reg == LM_ALL_OFF
		|=> o_rx_positive_int == $past(i_tx_positive_rail) &&
			o_rx_line_clock_int == $past(i_tx_line_clock))
		else $error("digital loopback rails not looped");
endmodule

// >>> rx_payload_sink.sv
/*
 * downstream payload sink that watches the receive serial-port clock pin.
 * assumes its inputs are settled on the port's i_ref_clk.
 */
`timescale 1ns/10ps
module rx_payload_sink (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_rx_clock_out,
	output logic      [15:0] o_toggles
);
	logic clk_seen_reg;
	// a gapped clock shows as a stalled count, not as a wrong level
	always_ff @(posedge i_ref_clk) begin
		clk_seen_reg <= i_rx_clock_out;
		if (i_rst) begin
			o_toggles <= 16'h0000;
		end else if (clk_seen_reg != i_rx_clock_out) begin
			o_toggles <= o_toggles + 16'h0001;
		end
	end
endmodule

// >>> tb.sv
/*
 * self-checking bench for the receive port pin-select block.
 * assumes sync active-high reset and mode decode two edges after a change.
 */
`timescale 1ns/10ps
module tb;
	import port_mode_pkg::*;
	logic i_ref_clk, i_rst, i_rx_frame_start_select, i_rx_clock_select;
	logic i_tx_zero_suppress_disable, i_rx_zero_suppress_disable;
	logic i_analog_loopback, i_bert_enable, i_rx_data_enable;
	logic i_rx_frame_start, i_rx_serial_data, i_frame_start_pin;
	logic i_code_violation, i_tx_line_clock, i_tx_positive_rail;
	logic i_tx_negative_rail, i_rx_line_clock, i_rx_positive_rail;
	logic i_rx_neg_or_violation_in, i_ovh_occur, i_tx_load;
	logic [2:0] i_framing_mode_field, i_line_mode_field;
	logic [7:0] i_ovh_value, i_tx_byte, o_rx_byte, o_ovh_stored;
	logic o_rx_serial_data_out, o_rx_enable_frame_out, o_rx_clock_out;
	logic o_frame_start_int, o_line_interface_unit, o_jitter_attenuator_tx;
	logic o_jitter_attenuator_rx, o_unipolar_line_mode, o_clear_channel_mode;
	logic o_ds3_rate, o_bert_active, o_rx_line_clock_int, o_rx_positive_int;
	logic o_rx_negative_int, o_tx_serial_bit, o_tx_busy, o_rx_byte_valid;
	logic o_ovh_unstable;
	logic [15:0] o_bipolar_violation_counter, toggles;
	line_code_t o_line_code;
	int mismatches = 0;
	int checks_done = 0;
	// ------------------------------------------------------------
	// clock, design and partner
	// ------------------------------------------------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	port_mode_rx_pin_select dut (.*);
	rx_payload_sink sink (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_rx_clock_out(o_rx_clock_out), .o_toggles(toggles));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wait_n(input int n);
		repeat (n) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask
	task automatic chk_bit(input string what, input logic e, input logic s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %b seen %b", what, e, s);
		end
	endtask
	task automatic chk_val(input string what, input logic [15:0] e,
		input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic set_modes(input logic [2:0] fm, input logic [2:0] lm);
		@(posedge i_ref_clk);
		i_framing_mode_field <= fm;
		i_line_mode_field <= lm;
		wait_n(3);
	endtask
	task automatic send_ovh(input logic [7:0] v);
		@(posedge i_ref_clk);
		i_ovh_occur <= 1'b1;
		i_ovh_value <= v;
		@(posedge i_ref_clk);
		i_ovh_occur <= 1'b0;
	endtask
	task automatic clk_runs(input logic e, input logic de,
		input logic cs);
		logic [15:0] c;
		@(posedge i_ref_clk);
		i_rx_data_enable <= de;
		i_rx_clock_select <= cs;
		wait_n(4);
		c = toggles;
		wait_n(12);
		chk_bit("clock runs", e, toggles !== c);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_framing;
		logic [2:0] fm;
		for (int m = 0; m < 8; m++) begin
			fm = 3'(m);
			set_modes(fm, LM_ALL_OFF);
			chk_bit("clear mode", fm[2], o_clear_channel_mode);
			chk_bit("ds3 rate", fm == 0 || fm == 1 || fm == 4, o_ds3_rate);
			chk_bit("bert", 1'b1, o_bert_active);
			chk_bit("en frame", fm[2] ? fm[1] : 1'b1, o_rx_enable_frame_out);
			chk_bit("frame int", ~fm[2], o_frame_start_int);
		end
		$display("test framing done");
	endtask
	task automatic t_line;
		line_code_t lc;
		logic [2:0] lm;
		for (int k = 0; k < 32; k++) begin
			lm = 3'(k);
			@(posedge i_ref_clk);
			i_tx_zero_suppress_disable <= k[3] | k[0];
			i_rx_zero_suppress_disable <= k[3];
			set_modes(k[4] ? FM_E3_G751 : FM_DS3_CBIT, lm);
			lc = lm[2] ? LC_NONE : k[3] ? LC_AMI : k[4] ? LC_HDB3 : LC_B3ZS;
			chk_val("line code", 16'(lc), 16'(o_line_code));
			chk_bit("liu", lm == 1 || lm == 2 || lm == 3,
				o_line_interface_unit);
			chk_bit("ja tx", lm == 2, o_jitter_attenuator_tx);
			chk_bit("ja rx", lm == 3, o_jitter_attenuator_rx);
			chk_bit("unipolar", lm[2], o_unipolar_line_mode);
		end
		$display("test line done");
	endtask
	task automatic t_enable;
		set_modes(FM_DS3_CBIT, LM_ALL_OFF);
		@(posedge i_ref_clk);
		i_rx_frame_start <= 1'b0;
		wait_n(2);
		chk_bit("data enable", 1'b1, o_rx_enable_frame_out);
		@(posedge i_ref_clk);
		i_rx_frame_start_select <= 1'b1;
		wait_n(3);
		chk_bit("frame start", 1'b0, o_rx_enable_frame_out);
		@(posedge i_ref_clk);
		i_rx_frame_start <= 1'b1;
		wait_n(2);
		chk_bit("frame start", 1'b1, o_rx_enable_frame_out);
		$display("test enable done");
	endtask
	task automatic t_clock;
		clk_runs(1'b0, 1'b0, 1'b0);
		clk_runs(1'b1, 1'b1, 1'b0);
		clk_runs(1'b1, 1'b0, 1'b1);
		set_modes(FM_DS3_CLEAR, LM_ALL_OFF);
		clk_runs(1'b1, 1'b0, 1'b0);
		$display("test clock done");
	endtask
	task automatic t_loop;
		set_modes(FM_DS3_CBIT, LM_ALL_OFF);
		@(posedge i_ref_clk);
		i_analog_loopback <= 1'b1;
		{i_tx_positive_rail, i_tx_negative_rail, i_tx_line_clock} <= 3'h7;
		wait_n(5);
		chk_bit("loop pos", 1'b1, o_rx_positive_int);
		chk_bit("loop neg", 1'b1, o_rx_negative_int);
		chk_bit("loop clk", 1'b1, o_rx_line_clock_int);
		set_modes(FM_DS3_CBIT, LM_LIU_ON);
		wait_n(3);
		chk_bit("no loop pos", 1'b0, o_rx_positive_int);
		$display("test loop done");
	endtask
	task automatic t_violation;
		logic [15:0] c;
		set_modes(FM_DS3_CBIT, 3'h4);
		c = o_bipolar_violation_counter;
		@(posedge i_ref_clk);
		i_code_violation <= 1'b1;
		@(posedge i_ref_clk);
		i_code_violation <= 1'b0;
		i_rx_neg_or_violation_in <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		i_rx_neg_or_violation_in <= 1'b0;
		wait_n(8);
		chk_val("bpv count", c + 16'h0001, o_bipolar_violation_counter);
		$display("test violation done");
	endtask
	// mid-run reset aligns the bit-rate divider and the byte counters
	task automatic t_serdes;
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		i_tx_byte <= 8'hc5;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		for (int c = 1; c <= 36; c++) begin
			@(posedge i_ref_clk);
			i_rx_serial_data <= o_tx_serial_bit;
			i_tx_load <= (c == 1);
			i_rx_data_enable <= (c >= 4);
		end
		@(negedge i_ref_clk);
		chk_bit("rx valid", 1'b1, o_rx_byte_valid);
		chk_val("rx byte", 16'h00c5, 16'(o_rx_byte));
		chk_bit("tx busy", 1'b0, o_tx_busy);
		chk_bit("serial out", 1'b1, o_rx_serial_data_out);
		$display("test serdes done");
	endtask
	task automatic t_integ;
		repeat (4) send_ovh(8'h5a);
		wait_n(1);
		chk_val("stored early", 16'h0000, 16'(o_ovh_stored));
		send_ovh(8'h5a);
		wait_n(1);
		chk_val("stored", 16'h005a, 16'(o_ovh_stored));
		for (int v = 1; v < 8; v++) send_ovh(8'(v));
		wait_n(1);
		chk_bit("unstable early", 1'b0, o_ovh_unstable);
		send_ovh(8'h08);
		wait_n(1);
		chk_bit("unstable", 1'b1, o_ovh_unstable);
		repeat (5) send_ovh(8'h33);
		wait_n(1);
		chk_bit("unstable clear", 1'b0, o_ovh_unstable);
		$display("test integration done");
	endtask
	// ------------------------------------------------------------
	// sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{i_rx_frame_start_select, i_rx_clock_select, i_analog_loopback} = '0;
		{i_tx_zero_suppress_disable, i_rx_zero_suppress_disable} = '0;
		{i_rx_serial_data, i_code_violation, i_tx_line_clock} = '0;
		{i_tx_positive_rail, i_tx_negative_rail, i_rx_line_clock} = '0;
		{i_rx_positive_rail, i_rx_neg_or_violation_in, i_ovh_occur} = '0;
		{i_tx_load, i_tx_byte, i_ovh_value} = '0;
		{i_bert_enable, i_rx_data_enable, i_rx_frame_start} = '1;
		i_frame_start_pin = 1'b1;
		i_framing_mode_field = FM_RESET;
		i_line_mode_field = LM_RESET;
		i_rst = 1'b1;
		repeat (12) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_integ();
		t_framing();
		t_line();
		t_enable();
		t_clock();
		t_loop();
		t_violation();
		t_serdes();
		close_out();
	end
	// the whole sequence needs well under 2000 cycles
	initial begin
		#200000;
		mismatches++;
		close_out();
	end
endmodule
